// ### srs_delay_cnt.sv
`timescale 1ns/100ps
// Down counter: held clear, loaded by start, one-cycle done pulse at the end
module srs_delay_cnt #(
  parameter int unsigned CNT_W = 13
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             clr_i,
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  busy_o,
  output logic                  done_o
);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             busy_q, busy_d;
  logic             done_q, done_d;

  if (CNT_W < 2) begin : g_chk
    $error("srs_delay_cnt: CNT_W too small");
  end

  // Clear dominates start so a held counter never runs
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (clr_i) begin
      cnt_d  = '0;
      busy_d = 1'b0;
    end else if (start_i && !busy_q) begin
      cnt_d  = len_i - CNT_W'(1);
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;

endmodule : srs_delay_cnt

// ### srs_far_model.sv
`timescale 1ns/100ps
// External reset line with its pull-up and a test switch to ground
module srs_far_model (
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe_n_o,
  input  wire logic ext_low_i,
  output logic      ext_rst_pin_o
);
  // Open drain: a released line floats high, never holds its last value
  always_comb begin
    ext_rst_pin_o = 1'b1;
    if (!rst_pin_oe_n_o) ext_rst_pin_o = rst_pin_o;
    if (ext_low_i) ext_rst_pin_o = 1'b0;
  end
endmodule : srs_far_model

// ### srs_pkg.sv
package srs_pkg;

  // Register addresses on the core's byte bus
  localparam logic [15:0] SRS_ADDR_BRK_STAT  = 16'hFE00;
  localparam logic [15:0] SRS_ADDR_RST_CAUSE = 16'hFE01;
  localparam logic [15:0] SRS_ADDR_BRK_CTRL  = 16'hFE03;

  // Break status field
  localparam int unsigned SRS_BIT_BRK_EXIT_WAIT = 1;

  // Reset cause fields
  localparam int unsigned SRS_BIT_POR     = 7;
  localparam int unsigned SRS_BIT_PIN     = 6;
  localparam int unsigned SRS_BIT_WDOG    = 5;
  localparam int unsigned SRS_BIT_BAD_OP  = 4;
  localparam int unsigned SRS_BIT_BAD_ADR = 3;
  localparam int unsigned SRS_BIT_BUS_RST = 2;
  localparam int unsigned SRS_BIT_LOW_V   = 1;

  // Break flag control field
  localparam int unsigned SRS_BIT_CLR_EN = 7;

  // Reset values
  localparam logic [7:0] SRS_RST_CAUSE_POR = 8'h80;
  localparam logic       SRS_RST_BRK_EXIT  = 1'b0;
  localparam logic       SRS_RST_CLR_EN    = 1'b0;

  // Timing counts in reference clock cycles
  localparam int unsigned SRS_STOP_REC_LONG  = 4096;
  localparam int unsigned SRS_STOP_REC_SHORT = 32;
  localparam int unsigned SRS_PIN_SAMPLE_DLY = 32;
  localparam int unsigned SRS_INT_RST_HOLD   = 16;

  // Power mode and reset sequencing states
  typedef enum logic [1:0] {
    SRS_MODE_RUN,
    SRS_MODE_WAIT,
    SRS_MODE_STOP,
    SRS_MODE_RECOVER
  } srs_mode_t;

  typedef enum logic [1:0] {
    SRS_RST_IDLE,
    SRS_RST_DRIVE,
    SRS_RST_SAMPLE
  } srs_rst_t;

endpackage : srs_pkg

// ### srs_sys_integ.sv
`timescale 1ns/100ps
module srs_sys_integ #(
  parameter int unsigned CNT_W    = 13,
  parameter int unsigned HOLD_CYC = srs_pkg::SRS_INT_RST_HOLD
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        stop_enter_i,
  input  wire logic        wait_enter_i,
  input  wire logic        irq_req_i,
  input  wire logic        break_req_i,
  input  wire logic        break_active_i,
  input  wire logic        short_stop_recovery_i,
  input  wire logic        ext_rst_pin_i,
  input  wire logic        wdog_rst_i,
  input  wire logic        bad_opcode_rst_i,
  input  wire logic        bad_fetch_rst_i,
  input  wire logic        bus_rst_i,
  input  wire logic        low_volt_rst_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  output logic             clock_gen_output_en_o,
  output logic             cpu_clk_en_o,
  output logic             stack_go_o,
  output logic             core_rst_n_o,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_n_o,
  output logic             flag_clear_allow_o
);

  localparam int unsigned PIN_W = 6;

  if (CNT_W < $clog2(srs_pkg::SRS_STOP_REC_LONG + 1)) begin : g_chk_w
    $error("srs_sys_integ: CNT_W cannot hold the long recovery");
  end
  if (HOLD_CYC < 1 || HOLD_CYC > 63) begin : g_chk_h
    $error("srs_sys_integ: HOLD_CYC out of range");
  end

  // Shared address decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction : hit

  srs_pkg::srs_mode_t mode_q, mode_d;
  srs_pkg::srs_rst_t  rphase_q, rphase_d;
  logic [PIN_W-1:0]   rcnt_q, rcnt_d;
  logic [7:0]         cause_q, cause_d;
  logic               brk_exit_q, brk_exit_d;
  logic               clr_en_q, clr_en_d;
  logic [7:0]         rdata_q, rdata_d;
  logic               clk_en_q, cpu_en_q, stack_q, core_rst_n_q, oe_n_q, allow_q;
  logic               rec_clr, rec_start, rec_busy, rec_done;
  logic [CNT_W-1:0]   rec_len;
  logic               int_rst, allow;

  // Any internally requested reset or a line pulled low from outside
  assign int_rst = wdog_rst_i | bad_opcode_rst_i | bad_fetch_rst_i | bus_rst_i
                 | low_volt_rst_i | (rphase_q == srs_pkg::SRS_RST_IDLE && !ext_rst_pin_i);
  // Outside break clearing is always allowed
  assign allow = !break_active_i || clr_en_q;

  // Power mode sequencing
  always_comb begin
    mode_d    = mode_q;
    rec_clr   = 1'b0;
    rec_start = 1'b0;
    case (mode_q)
      srs_pkg::SRS_MODE_RUN: begin
        if (stop_enter_i) begin
          mode_d = srs_pkg::SRS_MODE_STOP;
        end else if (wait_enter_i) begin
          mode_d = srs_pkg::SRS_MODE_WAIT;
        end
      end
      srs_pkg::SRS_MODE_WAIT: begin
        if (irq_req_i || break_req_i) begin
          mode_d = srs_pkg::SRS_MODE_RUN;
        end
      end
      srs_pkg::SRS_MODE_STOP: begin
        rec_clr = 1'b1;
        if (irq_req_i || break_req_i) begin
          mode_d    = srs_pkg::SRS_MODE_RECOVER;
          rec_clr   = 1'b0;
          rec_start = 1'b1;
        end
      end
      srs_pkg::SRS_MODE_RECOVER: begin
        if (rec_done) begin
          mode_d = srs_pkg::SRS_MODE_RUN;
        end
      end
      default: mode_d = srs_pkg::SRS_MODE_RUN;
    endcase
    // Reset leaves any low-power mode at once
    if (int_rst || rphase_q != srs_pkg::SRS_RST_IDLE) begin
      mode_d  = srs_pkg::SRS_MODE_RUN;
      rec_clr = 1'b1;
    end
  end

  // Stop recovery length; long default suits slow crystal start-up
  assign rec_len = short_stop_recovery_i ? CNT_W'(srs_pkg::SRS_STOP_REC_SHORT)
                                         : CNT_W'(srs_pkg::SRS_STOP_REC_LONG);

  srs_delay_cnt #(
    .CNT_W (CNT_W)
  ) u_rec_cnt (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .clr_i     (rec_clr),
    .start_i   (rec_start),
    .len_i     (rec_len),
    .busy_o    (rec_busy),
    .done_o    (rec_done)
  );

  // Reset line drive, release and late sample
  always_comb begin
    rphase_d = rphase_q;
    rcnt_d   = rcnt_q;
    case (rphase_q)
      srs_pkg::SRS_RST_IDLE: begin
        if (int_rst) begin
          rphase_d = srs_pkg::SRS_RST_DRIVE;
          rcnt_d   = PIN_W'(HOLD_CYC - 1);
        end
      end
      srs_pkg::SRS_RST_DRIVE: begin
        if (rcnt_q == '0) begin
          rphase_d = srs_pkg::SRS_RST_SAMPLE;
          rcnt_d   = PIN_W'(srs_pkg::SRS_PIN_SAMPLE_DLY - 1);
        end else begin
          rcnt_d = rcnt_q - PIN_W'(1);
        end
      end
      srs_pkg::SRS_RST_SAMPLE: begin
        if (rcnt_q == '0) begin
          rphase_d = srs_pkg::SRS_RST_IDLE;
        end else begin
          rcnt_d = rcnt_q - PIN_W'(1);
        end
      end
      default: rphase_d = srs_pkg::SRS_RST_IDLE;
    endcase
  end

  // Registers: read clears causes when clearing is allowed, but a new cause in the same cycle wins
  always_comb begin
    cause_d    = cause_q;
    brk_exit_d = brk_exit_q;
    clr_en_d   = clr_en_q;
    rdata_d    = rdata_q;
    if (reg_rd_i) begin
      rdata_d = 8'h00;
      if (hit(reg_addr_i, srs_pkg::SRS_ADDR_BRK_STAT)) begin
        rdata_d[srs_pkg::SRS_BIT_BRK_EXIT_WAIT] = brk_exit_q;
      end else if (hit(reg_addr_i, srs_pkg::SRS_ADDR_RST_CAUSE)) begin
        rdata_d = cause_q;
        if (allow) begin
          cause_d = 8'h00;
        end
      end else if (hit(reg_addr_i, srs_pkg::SRS_ADDR_BRK_CTRL)) begin
        rdata_d[srs_pkg::SRS_BIT_CLR_EN] = clr_en_q;
      end
    end
    if (reg_wr_i) begin
      if (hit(reg_addr_i, srs_pkg::SRS_ADDR_BRK_CTRL)) begin
        clr_en_d = reg_wdata_i[srs_pkg::SRS_BIT_CLR_EN];
      end else if (hit(reg_addr_i, srs_pkg::SRS_ADDR_BRK_STAT) && allow
                   && !reg_wdata_i[srs_pkg::SRS_BIT_BRK_EXIT_WAIT]) begin
        brk_exit_d = 1'b0;
      end
    end
    if (mode_q == srs_pkg::SRS_MODE_WAIT && break_req_i) begin
      brk_exit_d = 1'b1;
    end
    // Set terms OR in so flags accumulate
    cause_d[srs_pkg::SRS_BIT_WDOG]    = cause_d[srs_pkg::SRS_BIT_WDOG]    | wdog_rst_i;
    cause_d[srs_pkg::SRS_BIT_BAD_OP]  = cause_d[srs_pkg::SRS_BIT_BAD_OP]  | bad_opcode_rst_i;
    cause_d[srs_pkg::SRS_BIT_BAD_ADR] = cause_d[srs_pkg::SRS_BIT_BAD_ADR] | bad_fetch_rst_i;
    cause_d[srs_pkg::SRS_BIT_BUS_RST] = cause_d[srs_pkg::SRS_BIT_BUS_RST] | bus_rst_i;
    cause_d[srs_pkg::SRS_BIT_LOW_V]   = cause_d[srs_pkg::SRS_BIT_LOW_V]   | low_volt_rst_i;
    if ((rphase_q == srs_pkg::SRS_RST_IDLE && !ext_rst_pin_i)
        || (rphase_q == srs_pkg::SRS_RST_SAMPLE && rcnt_q == '0 && !ext_rst_pin_i)) begin
      cause_d[srs_pkg::SRS_BIT_PIN] = 1'b1;
    end
  end

  // Power-on reset loads the cause register with only the power-on flag
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      mode_q       <= srs_pkg::SRS_MODE_RUN;
      rphase_q     <= srs_pkg::SRS_RST_DRIVE;
      rcnt_q       <= PIN_W'(HOLD_CYC - 1);
      cause_q      <= srs_pkg::SRS_RST_CAUSE_POR;
      brk_exit_q   <= srs_pkg::SRS_RST_BRK_EXIT;
      clr_en_q     <= srs_pkg::SRS_RST_CLR_EN;
      rdata_q      <= 8'h00;
      clk_en_q     <= 1'b1;
      cpu_en_q     <= 1'b1;
      stack_q      <= 1'b0;
      core_rst_n_q <= 1'b0;
      oe_n_q       <= 1'b0;
      allow_q      <= 1'b1;
    end else begin
      mode_q       <= mode_d;
      rphase_q     <= rphase_d;
      rcnt_q       <= rcnt_d;
      cause_q      <= cause_d;
      brk_exit_q   <= brk_exit_d;
      clr_en_q     <= clr_en_d;
      rdata_q      <= rdata_d;
      clk_en_q     <= mode_d != srs_pkg::SRS_MODE_STOP;
      cpu_en_q     <= mode_d == srs_pkg::SRS_MODE_RUN;
      stack_q      <= rec_done && mode_q == srs_pkg::SRS_MODE_RECOVER;
      core_rst_n_q <= rphase_d == srs_pkg::SRS_RST_IDLE;
      oe_n_q       <= rphase_d != srs_pkg::SRS_RST_DRIVE;
      allow_q      <= allow;
    end
  end

  assign reg_rdata_o           = rdata_q;
  assign clock_gen_output_en_o = clk_en_q;
  assign cpu_clk_en_o          = cpu_en_q;
  assign stack_go_o            = stack_q;
  assign core_rst_n_o          = core_rst_n_q;
  assign rst_pin_o             = 1'b0;
  assign rst_pin_oe_n_o        = oe_n_q;
  assign flag_clear_allow_o    = allow_q;

  // Helper: cycles spent in recovery
  logic [CNT_W:0] rec_age_q;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || mode_q != srs_pkg::SRS_MODE_RECOVER) begin
      rec_age_q <= '0;
    end else begin
      rec_age_q <= rec_age_q + (CNT_W+1)'(1);
    end
  end

  sequence s_stop_wake;
    mode_q == srs_pkg::SRS_MODE_STOP && (irq_req_i || break_req_i) && !int_rst
      && rphase_q == srs_pkg::SRS_RST_IDLE;
  endsequence

  property p_stop_gate;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      mode_q == srs_pkg::SRS_MODE_STOP |-> !clock_gen_output_en_o;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("clock not gated in stop");

  property p_stop_clear;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      mode_q == srs_pkg::SRS_MODE_STOP && !(irq_req_i || break_req_i) |=> !rec_busy;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("counter runs in stop");

  property p_wake;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      s_stop_wake |=> mode_q == srs_pkg::SRS_MODE_RECOVER && rec_busy;
  endproperty
  a_wake: assert property (p_wake) else $error("no exit from stop");

  property p_rec_len;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(stack_go_o) |-> (rec_age_q == (short_stop_recovery_i ? 33 : 4097));
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("wrong recovery length");

  property p_no_early_stack;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      mode_q == srs_pkg::SRS_MODE_RECOVER && rec_busy |=> !stack_go_o;
  endproperty
  a_no_early_stack: assert property (p_no_early_stack) else $error("early stacking");

  property p_read_clear;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      reg_rd_i && reg_addr_i == srs_pkg::SRS_ADDR_RST_CAUSE && allow && !int_rst
        && rphase_q != srs_pkg::SRS_RST_SAMPLE ##1 1'b1
      |-> cause_q == 8'h00 && reg_rdata_o == $past(cause_q);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("cause not cleared by read");

  property p_por_cause;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !$past(nrst_i) |-> cause_q == srs_pkg::SRS_RST_CAUSE_POR && !rst_pin_oe_n_o;
  endproperty
  a_por_cause: assert property (p_por_cause) else $error("bad state after power-on");

  property p_pin_drive;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(rst_pin_oe_n_o) |-> !core_rst_n_o [*8];
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("sample window too short");

  property p_wdog;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      wdog_rst_i |=> cause_q[srs_pkg::SRS_BIT_WDOG] ##1 !rst_pin_oe_n_o;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset not handled");

  property p_brk_exit;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      mode_q == srs_pkg::SRS_MODE_WAIT && break_req_i |=> brk_exit_q;
  endproperty
  a_brk_exit: assert property (p_brk_exit) else $error("break exit flag not set");

  property p_allow;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      break_active_i && !clr_en_q |=> !flag_clear_allow_o;
  endproperty
  a_allow: assert property (p_allow) else $error("clearing allowed in break");

endmodule : srs_sys_integ

// ### stop_recovery_reset_status_tb.sv
`timescale 1ns/100ps
module stop_recovery_reset_status_tb;
  logic        ref_clk_i;
  logic        nrst_i;
  logic        stop_en, wait_en, irq, brk, brk_act, short_rec, ext_low;
  logic [4:0]  rst_req;
  logic [15:0] addr;
  logic        rd, wr;
  logic [7:0]  wdata, rdata, v;
  logic        clk_en, cpu_en, stack_go, core_n, pin_o, pin_oe_n, clr_ok, line;
  int          n_errors, check_count;

  srs_sys_integ dut (
    .ref_clk_i            (ref_clk_i),
    .nrst_i               (nrst_i),
    .stop_enter_i         (stop_en),
    .wait_enter_i         (wait_en),
    .irq_req_i            (irq),
    .break_req_i          (brk),
    .break_active_i       (brk_act),
    .short_stop_recovery_i(short_rec),
    .ext_rst_pin_i        (line),
    .wdog_rst_i           (rst_req[0]),
    .bad_opcode_rst_i     (rst_req[1]),
    .bad_fetch_rst_i      (rst_req[2]),
    .bus_rst_i            (rst_req[3]),
    .low_volt_rst_i       (rst_req[4]),
    .reg_addr_i           (addr),
    .reg_rd_i             (rd),
    .reg_wr_i             (wr),
    .reg_wdata_i          (wdata),
    .reg_rdata_o          (rdata),
    .clock_gen_output_en_o(clk_en),
    .cpu_clk_en_o         (cpu_en),
    .stack_go_o           (stack_go),
    .core_rst_n_o         (core_n),
    .rst_pin_o            (pin_o),
    .rst_pin_oe_n_o       (pin_oe_n),
    .flag_clear_allow_o   (clr_ok)
  );

  srs_far_model far (
    .rst_pin_o     (pin_o),
    .rst_pin_oe_n_o(pin_oe_n),
    .ext_low_i     (ext_low),
    .ext_rst_pin_o (line)
  );

  // 25 MHz reference clock
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc

  // Read data lands one cycle after the strobe edge
  task automatic rd_chk(string what, logic [15:0] a, logic [7:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk(what, exp, rdata);
  endtask : rd_chk

  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic pulse_rst(int i);
    @(posedge ref_clk_i);
    rst_req <= 5'h01 << i;
    @(posedge ref_clk_i);
    rst_req <= 5'h00;
  endtask : pulse_rst

  // Bounded wait for the core reset to fall and then come out
  task automatic wait_core();
    int k;
    k = 0;
    while (core_n !== 1'b0 && k < 20) begin
      @(posedge ref_clk_i);
      k++;
    end
    while (core_n !== 1'b1 && k < 400) begin
      @(posedge ref_clk_i);
      k++;
    end
    chk("core reset released", 16'h0001, {15'h0000, core_n});
  endtask : wait_core

  function automatic logic [15:0] rec_cycles(logic s);
    // Offset of 2: wake edge one after the drive edge, one extra recover cycle
    return 16'((s ? srs_pkg::SRS_STOP_REC_SHORT : srs_pkg::SRS_STOP_REC_LONG) + 2);
  endfunction : rec_cycles

  // Enter stop, wake by interrupt or break, time the stacking pulse
  task automatic stop_run(logic s, logic b);
    int n;
    @(posedge ref_clk_i);
    short_rec <= s;
    stop_en <= 1'b1;
    @(posedge ref_clk_i);
    stop_en <= 1'b0;
    cyc(2);
    #1 chk("clock gen off in stop", 16'h0000, {15'h0000, clk_en});
    @(posedge ref_clk_i);
    if (b) brk <= 1'b1;
    else irq <= 1'b1;
    n = 0;
    while (stack_go !== 1'b1 && n < 5000) begin
      @(posedge ref_clk_i);
      #1 n++;
      if (n == 3) chk("clock gen on after wake", 16'h0001, {15'h0000, clk_en});
      if (n == 3) chk("cpu clock off in recovery", 16'h0000, {15'h0000, cpu_en});
    end
    chk("stack delay", rec_cycles(s), n[15:0]);
    chk("cpu clock on after recovery", 16'h0001, {15'h0000, cpu_en});
    @(posedge ref_clk_i);
    irq <= 1'b0;
    brk <= 1'b0;
    #1 chk("stack pulse one cycle", 16'h0000, {15'h0000, stack_go});
    cyc(3);
  endtask : stop_run

  // Hang guard, 20000 cycles, well above the few thousand the run needs
  initial begin
    #(40 * 20000);
    n_errors++;
    $display("[FAIL] watchdog expired");
    tally_and_finish();
  end

  initial begin
    {stop_en, wait_en, irq, brk, brk_act, short_rec, ext_low, rd, wr} = '0;
    rst_req = 5'h00;
    addr = 16'h0000;
    wdata = 8'h00;
    nrst_i = 1'b0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'hA4B637C1));
    cyc(16);
    nrst_i <= 1'b1;
    wait_core();
    rd_chk("cause after power-on", 16'hFE01, 8'h80);
    rd_chk("cause after read", 16'hFE01, 8'h00);
    rd_chk("break status", 16'hFE00, 8'h00);
    rd_chk("clear enable", 16'hFE03, 8'h00);
    // Random control writes and random unmapped traffic
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      wr_reg(16'hFE03, v);
      rd_chk("clear enable rw", 16'hFE03, v & 8'h80);
      wr_reg({8'hFD, v}, ~v);
      rd_chk("unmapped", {8'hFD, v}, 8'h00);
    end
    wr_reg(16'hFE03, 8'h00);
    // Each internal reset source, line pulled low meanwhile
    for (int i = 0; i < 5; i++) begin
      pulse_rst(i);
      cyc(3);
      #1 chk("line low in reset", 16'h0000, {15'h0000, line});
      wait_core();
      rd_chk("cause bit", 16'hFE01, 8'h01 << (5 - i));
    end
    pulse_rst(3);
    wait_core();
    pulse_rst(4);
    wait_core();
    rd_chk("accumulated causes", 16'hFE01, 8'h06);
    @(posedge ref_clk_i);
    ext_low <= 1'b1;
    cyc(2);
    ext_low <= 1'b0;
    wait_core();
    rd_chk("pin cause", 16'hFE01, 8'h40);
    pulse_rst(0);
    ext_low <= 1'b1;
    cyc(60);
    ext_low <= 1'b0;
    wait_core();
    wait_core();
    rd_chk("line still low at sample", 16'hFE01, 8'h60);
    // Protected cause read during break
    pulse_rst(0);
    wait_core();
    brk_act <= 1'b1;
    cyc(2);
    rd_chk("protected cause", 16'hFE01, 8'h20);
    rd_chk("protected cause kept", 16'hFE01, 8'h20);
    brk_act <= 1'b0;
    rd_chk("cause read after break", 16'hFE01, 8'h20);
    rd_chk("cause cleared", 16'hFE01, 8'h00);
    // Break ends wait mode
    @(posedge ref_clk_i);
    wait_en <= 1'b1;
    @(posedge ref_clk_i);
    wait_en <= 1'b0;
    brk <= 1'b1;
    brk_act <= 1'b1;
    @(posedge ref_clk_i);
    brk <= 1'b0;
    cyc(2);
    rd_chk("break exit flag", 16'hFE00, 8'h02);
    chk("clear blocked", 16'h0000, {15'h0000, clr_ok});
    wr_reg(16'hFE00, 8'h00);
    rd_chk("flag protected", 16'hFE00, 8'h02);
    wr_reg(16'hFE03, 8'h80);
    cyc(2);
    chk("clear allowed", 16'h0001, {15'h0000, clr_ok});
    wr_reg(16'hFE00, 8'h00);
    wr_reg(16'hFE03, 8'h00);
    brk_act <= 1'b0;
    rd_chk("flag stays cleared", 16'hFE00, 8'h00);
    // Interrupt ends wait mode: flag stays clear
    @(posedge ref_clk_i);
    wait_en <= 1'b1;
    @(posedge ref_clk_i);
    wait_en <= 1'b0;
    irq <= 1'b1;
    cyc(2);
    irq <= 1'b0;
    cyc(3);
    rd_chk("irq wait exit", 16'hFE00, 8'h00);
    stop_run(1'b1, 1'b0);
    stop_run(1'b0, 1'b0);
    stop_run(1'b1, 1'b1);
    tally_and_finish();
  end
endmodule : stop_recovery_reset_status_tb
